// >>> logic/dtg_pkg.sv
// Shared constants, types and code decoding for the tone code link
package dtg_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int TONE_START_DLY_US = 6000; // Start delay after enable
	localparam int TONE_START_DLY_CYC = (CLK_HZ / 1_000_000)
		* TONE_START_DLY_US;
	localparam int OSC_START_US = 0;        // Modelled start-up time
	localparam int OSC_START_MAX_US = 10000;
	localparam int OSC_START_CYC = (CLK_HZ / 1_000_000) * OSC_START_US;
	localparam int SCLK_TYP_HZ = 100_000;
	localparam int SCLK_MAX_HZ = 500_000;
	// Longest half period that keeps the link at its typical rate
	localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_TYP_HZ);
	localparam int PAR_SETUP_NS = 1000;     // Host data setup before enable
	localparam int PAR_SETUP_CYC = (PAR_SETUP_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;

	// ------------------------------------------------------------------
	// Code layout
	// ------------------------------------------------------------------
	localparam int CODE_W = 5;
	localparam int PAR_W = 4;
	localparam int CODE_TOP_POS = 4;        // Top code bit selects single
	localparam logic [4:0] CODE_OFF = 5'h1f;
	localparam logic [4:0] CODE_RST = 5'h1f;
	localparam int SINGLE_COL_POS = 2;      // In single codes: column group

	// Synchronised pin vector positions and reset value
	localparam int PIN_W = 8;
	localparam int PIN_MODE = 7;
	localparam int PIN_CE_N = 6;
	localparam int PIN_SCLK = 5;
	localparam int PIN_SDATA = 4;
	localparam logic [7:0] PIN_RST = 8'h60;

	// ------------------------------------------------------------------
	// Tone table: realised frequencies derived from the clock
	// ------------------------------------------------------------------
	localparam int TONE_W = 20;
	localparam int ROW_HZ [4] = '{699, 766, 847, 948};
	localparam int COL_HZ [4] = '{1215, 1332, 1472, 1633};

	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_WAIT = 2'b01,
		DEV_RUN = 2'b11
	} dtg_dev_state_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_HIGH = 2'b01,
		HST_LOW = 2'b11
	} dtg_host_state_t;

	typedef struct packed {
		logic row_en;
		logic col_en;
		logic [1:0] row;
		logic [1:0] col;
	} dtg_sel_t;

	function automatic logic [TONE_W-1:0] dtg_half(input int hz);
		dtg_half = TONE_W'(CLK_HZ / (2 * hz));
	endfunction : dtg_half

	// Dual pair for a 4-bit digit code, row and column index
	function automatic dtg_sel_t dtg_dual(input logic [3:0] c);
		dtg_sel_t s;
		s = '{row_en: 1'b1, col_en: 1'b1, row: 2'd3, col: 2'd3};
		case (c)
			4'h1: {s.row, s.col} = {2'd0, 2'd0};
			4'h2: {s.row, s.col} = {2'd0, 2'd1};
			4'h3: {s.row, s.col} = {2'd0, 2'd2};
			4'h4: {s.row, s.col} = {2'd1, 2'd0};
			4'h5: {s.row, s.col} = {2'd1, 2'd1};
			4'h6: {s.row, s.col} = {2'd1, 2'd2};
			4'h7: {s.row, s.col} = {2'd2, 2'd0};
			4'h8: {s.row, s.col} = {2'd2, 2'd1};
			4'h9: {s.row, s.col} = {2'd2, 2'd2};
			4'ha: {s.row, s.col} = {2'd3, 2'd1};
			4'hb: {s.row, s.col} = {2'd3, 2'd0};
			4'hc: {s.row, s.col} = {2'd3, 2'd2};
			4'hd: {s.row, s.col} = {2'd0, 2'd3};
			4'he: {s.row, s.col} = {2'd1, 2'd3};
			4'hf: {s.row, s.col} = {2'd2, 2'd3};
			default: {s.row, s.col} = {2'd3, 2'd3};
		endcase
		return s;
	endfunction : dtg_dual

endpackage : dtg_pkg

// >>> logic/dtg_if.sv
// Pin bundle between the host controller and the tone code receiver
`timescale 1ns/1ps
`default_nettype none
interface dtg_if;
	logic mode_par;           // High: parallel, low: serial
	logic ce_n;               // Chip enable, active low
	logic sclk;               // Serial clock, sampled on falling edge
	logic sdata;              // Serial data, least significant bit first
	logic [3:0] par_code;     // Parallel code inputs

	modport dev (
		input mode_par,
		input ce_n,
		input sclk,
		input sdata,
		input par_code
	);

	modport host (
		output mode_par,
		output ce_n,
		output sclk,
		output sdata,
		output par_code
	);
endinterface : dtg_if
`default_nettype wire

// >>> logic/dtg_tone_osc.sv
// Square-wave tone oscillator with a run-time half period
`timescale 1ns/1ps
`default_nettype none
module dtg_tone_osc
	import dtg_pkg::*;
#(
	parameter int W = TONE_W
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic [W-1:0] half_cyc,
	output logic wave
);
	logic [W-1:0] cnt_r;
	logic wave_r;

	// Counter restarts on disable so each tone started after a disable begins with a full half cycle
	always_ff @(posedge clk)
	begin
		if (!rstn || !en)
		begin
			cnt_r <= '0;
			wave_r <= 1'b0;
		end
		else if (cnt_r >= half_cyc - W'(1))
		begin
			cnt_r <= '0;
			wave_r <= ~wave_r;
		end
		else
			cnt_r <= cnt_r + W'(1);
	end

	assign wave = wave_r;
endmodule : dtg_tone_osc
`default_nettype wire

// >>> logic/dtg_device.sv
// Tone code receiver: serial and parallel code capture, tone selection
//
// Behaviour
// [RULE1] Serial command is five bits, LSB first
// [RULE2] Sample serial data on falling serial clock
// [RULE3] Top bit zero selects digit dual tone pair
// [RULE4] Codes 10000-10111 give one single tone each
// [RULE5] All-ones serial code stops tone output
// [RULE6] Host sends only defined codes; bit four MSB
// [RULE7] Host holds mode select low for serial
// [RULE8] Host holds mode select high for parallel
// [RULE9] Parallel: mode, then code, then enable low; host sets mode and code together
// [RULE10] Parallel tone starts about 6 ms after enable
// [RULE11] Parallel 4-bit codes select dual pairs only
// [RULE12] Parallel code stable before enable falls
// [RULE13] Host actively drives all four parallel inputs
// [RULE14] Tones approximate nominal frequencies from clock
// [RULE15] Delay is oscillator start plus about 6 ms
// [RULE16] Host serial clock at most 500 kHz
// [RULE17] Apply serial code after fifth falling edge
`timescale 1ns/1ps
`default_nettype none
module dtg_device
	import dtg_pkg::*;
#(
	parameter int START_DLY_CYC = TONE_START_DLY_CYC,
	parameter int OSC_DLY_CYC = OSC_START_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	dtg_if.dev link,
	output logic tone_row,
	output logic tone_col,
	output logic row_active,
	output logic col_active,
	output logic [4:0] applied_code,
	output logic code_pulse
);
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] sync1_r;
	logic [PIN_W-1:0] sync2_r;
	logic [PIN_W-1:0] sync3_r;
	logic [PIN_W-1:0] pin_r;
	logic [PIN_W-1:0] pin_nxt;
	logic sclk_prev_r;
	logic ce_n_prev_r;

	assign pin_raw = {link.mode_par, link.ce_n, link.sclk, link.sdata,
		link.par_code};

	// Three stages; a bit only moves once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1_r <= PIN_RST;
			sync2_r <= PIN_RST;
			sync3_r <= PIN_RST;
		end
		else
		begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Agreeing bits are taken, disagreeing bits hold their old value
	assign pin_nxt = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pin_r <= PIN_RST;
			sclk_prev_r <= 1'b1;
			ce_n_prev_r <= 1'b1;
		end
		else
		begin
			pin_r <= pin_nxt;
			sclk_prev_r <= pin_r[PIN_SCLK];
			ce_n_prev_r <= pin_r[PIN_CE_N];
		end
	end

	logic par_mode;
	logic enabled;
	logic sclk_fall;
	logic ce_fall;

	assign par_mode = pin_r[PIN_MODE];
	assign enabled = !pin_r[PIN_CE_N];
	assign sclk_fall = sclk_prev_r && !pin_r[PIN_SCLK];
	assign ce_fall = ce_n_prev_r && !pin_r[PIN_CE_N];

	// ------------------------------------------------------------------
	// Serial capture
	// ------------------------------------------------------------------
	logic [CODE_W-1:0] shift_r;
	logic [2:0] bit_cnt_r;
	logic ser_done;
	logic [CODE_W-1:0] ser_word;

	assign ser_word = {pin_r[PIN_SDATA], shift_r[CODE_W-1:1]}; // [RULE1]
	// Word completes on the fifth sampled falling edge
	assign ser_done = !par_mode && enabled && sclk_fall
		&& bit_cnt_r == 3'(CODE_W - 1); // [RULE17]

	// Bits enter at the top and walk down, so the first lands in bit 0.
	// Disable or a mode change drops a half-sent word.
	always_ff @(posedge clk)
	begin
		if (!rstn || par_mode || !enabled)
		begin
			shift_r <= '0;
			bit_cnt_r <= '0;
		end
		else if (sclk_fall) // [RULE2]
		begin
			shift_r <= ser_word; // [RULE1]
			bit_cnt_r <= ser_done ? 3'd0 : bit_cnt_r + 3'd1;
		end
	end

	// Serial code to tone selection; undefined codes silence the output
	function automatic dtg_sel_t ser_decode(input logic [4:0] c);
		dtg_sel_t s;
		s = '0;
		if (!c[CODE_TOP_POS])
			s = dtg_dual(c[3:0]); // [RULE3]
		else if (c[3])
			s = '0; // [RULE5] all ones and unused codes give silence
		else if (c[SINGLE_COL_POS])
		begin
			s.col_en = 1'b1; // [RULE4]
			s.col = c[1:0];
		end
		else
		begin
			s.row_en = 1'b1; // [RULE4]
			s.row = c[1:0];
		end
		return s;
	endfunction : ser_decode

	// ------------------------------------------------------------------
	// Parallel start sequence
	// ------------------------------------------------------------------
	localparam int DLY_CYC = OSC_DLY_CYC + START_DLY_CYC;
	dtg_dev_state_t state_r;
	logic [31:0] dly_r;
	logic par_start;

	// Enable low is required throughout the wait; raising it aborts
	assign par_start = state_r == DEV_WAIT && dly_r == 32'(DLY_CYC - 1);

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_r <= DEV_IDLE;
			dly_r <= '0;
		end
		else if (!par_mode || !enabled)
		begin
			state_r <= DEV_IDLE;
			dly_r <= '0;
		end
		else
		begin
			case (state_r)
				DEV_IDLE:
				begin
					dly_r <= '0;
					if (ce_fall)
						state_r <= DEV_WAIT;
				end
				DEV_WAIT:
				begin
					dly_r <= dly_r + 32'd1; // [RULE10] [RULE15]
					if (par_start)
						state_r <= DEV_RUN;
				end
				DEV_RUN:
					state_r <= DEV_RUN;
				default:
					state_r <= DEV_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Tone selection register
	// ------------------------------------------------------------------
	dtg_sel_t sel_r;
	logic [4:0] code_r;
	logic pulse_r;
	logic mode_prev_r;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sel_r <= '0;
			code_r <= CODE_RST;
			pulse_r <= 1'b0;
			mode_prev_r <= 1'b0;
		end
		else
		begin
			mode_prev_r <= par_mode;
			pulse_r <= ser_done || par_start;
			if (ser_done)
			begin
				sel_r <= ser_decode(ser_word); // [RULE17]
				code_r <= ser_word;
			end
			else if (par_start)
			begin
				// Code sampled at the end of the delay, held steady by host
				sel_r <= dtg_dual(pin_r[PAR_W-1:0]); // [RULE11]
				code_r <= {1'b0, pin_r[PAR_W-1:0]};
			end
			else if (!enabled || par_mode != mode_prev_r)
			begin
				sel_r <= '0;
				code_r <= CODE_OFF;
			end
			else if (par_mode && state_r != DEV_RUN)
				sel_r <= '0;
		end
	end

	// ------------------------------------------------------------------
	// Tone oscillators
	// ------------------------------------------------------------------
	logic [TONE_W-1:0] row_half;
	logic [TONE_W-1:0] col_half;

	// Half periods from the clock rate give the realised tones
	always_comb
	begin
		row_half = dtg_half(ROW_HZ[sel_r.row]); // [RULE14]
		col_half = dtg_half(COL_HZ[sel_r.col]); // [RULE14]
	end

	dtg_tone_osc #(
		.W(TONE_W)
	) u_row (
		.clk(clk),
		.rstn(rstn),
		.en(sel_r.row_en),
		.half_cyc(row_half),
		.wave(tone_row)
	);

	dtg_tone_osc #(
		.W(TONE_W)
	) u_col (
		.clk(clk),
		.rstn(rstn),
		.en(sel_r.col_en),
		.half_cyc(col_half),
		.wave(tone_col)
	);

	assign row_active = sel_r.row_en;
	assign col_active = sel_r.col_en;
	assign applied_code = code_r;
	assign code_pulse = pulse_r;
endmodule : dtg_device
`default_nettype wire

// >>> logic/dtg_host.sv
// Host controller: turns user commands into serial or parallel pin sequences
`timescale 1ns/1ps
`default_nettype none
module dtg_host
	import dtg_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC,
	parameter int SETUP_CYC = PAR_SETUP_CYC
)(
	input wire logic clk,
	input wire logic rstn,
	dtg_if.host link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_par,
	input wire logic [4:0] cmd_code
);
	dtg_host_state_t state_r;
	logic mode_r;
	logic ce_n_r;
	logic sclk_r;
	logic sdata_r;
	logic [PAR_W-1:0] par_r;
	logic [CODE_W-1:0] shift_r;
	logic [2:0] bit_r;
	logic [31:0] tmr_r;
	logic tmr_done;
	logic take;

	assign cmd_ready = state_r == HST_IDLE;
	assign take = cmd_valid && cmd_ready;
	// Half period keeps the clock at or under its ceiling [RULE16]
	assign tmr_done = tmr_r == 32'(HALF_CYC - 1);

	// ------------------------------------------------------------------
	// Pin sequencer
	// ------------------------------------------------------------------
	// Parallel: enable goes high, mode and code settle, then enable falls.
	// Serial: each bit is set with the clock high, then the clock falls.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_r <= HST_IDLE;
			mode_r <= 1'b0;
			ce_n_r <= 1'b1;
			sclk_r <= 1'b1;
			sdata_r <= 1'b0;
			par_r <= '0;
			shift_r <= '0;
			bit_r <= '0;
			tmr_r <= '0;
		end
		else
		begin
			case (state_r)
				HST_IDLE:
				begin
					tmr_r <= '0;
					bit_r <= '0;
					if (take && cmd_par)
					begin
						mode_r <= 1'b1; // [RULE8] [RULE9]
						ce_n_r <= 1'b1;
						par_r <= cmd_code[PAR_W-1:0]; // [RULE13]
						state_r <= HST_HIGH;
					end
					else if (take)
					begin
						mode_r <= 1'b0; // [RULE7]
						ce_n_r <= 1'b0;
						shift_r <= cmd_code; // [RULE6]
						sdata_r <= cmd_code[0]; // [RULE1]
						state_r <= HST_HIGH;
					end
				end
				HST_HIGH:
				begin
					tmr_r <= tmr_r + 32'd1;
					if (mode_r && tmr_r == 32'(SETUP_CYC - 1))
					begin
						ce_n_r <= 1'b0; // [RULE9] [RULE12]
						state_r <= HST_IDLE;
					end
					else if (!mode_r && tmr_done)
					begin
						tmr_r <= '0;
						sclk_r <= 1'b0;
						state_r <= HST_LOW;
					end
				end
				HST_LOW:
				begin
					tmr_r <= tmr_r + 32'd1;
					if (tmr_done)
					begin
						tmr_r <= '0;
						sclk_r <= 1'b1;
						shift_r <= {1'b0, shift_r[CODE_W-1:1]};
						sdata_r <= shift_r[1]; // [RULE1]
						bit_r <= bit_r + 3'd1;
						state_r <= bit_r == 3'(CODE_W - 1) ? HST_IDLE
							: HST_HIGH;
					end
				end
				default:
					state_r <= HST_IDLE;
			endcase
		end
	end

	assign link.mode_par = mode_r;
	assign link.ce_n = ce_n_r;
	assign link.sclk = sclk_r;
	assign link.sdata = sdata_r;
	assign link.par_code = par_r;
endmodule : dtg_host
`default_nettype wire

// >>> tb/dtg_link_asserts.sv
// Checker for the tone code link and the receiver's outcome
`timescale 1ns/1ps
`default_nettype none
module dtg_link_chk
	import dtg_pkg::*;
#(
	parameter int DLY = 20
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic mode_par,
	input wire logic ce_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic [3:0] par_code,
	input wire logic row_active,
	input wire logic col_active,
	input wire logic [4:0] applied_code,
	input wire logic code_pulse
);
	// ------------------------------------------------------------
	// Helper logic on the wire side
	// ------------------------------------------------------------
	logic sclk_r;
	logic [2:0] fall_r;
	logic [4:0] sh_r;
	int wait_r;

	// Previous serial clock level, for fall detection
	always_ff @(posedge clk)
	begin
		sclk_r <= sclk;
	end

	// Falls per word; wraps after five so the next word starts at one
	always_ff @(posedge clk)
	begin
		if (!rstn || ce_n || mode_par)
			fall_r <= 3'h0;
		else if (sclk_r && !sclk)
			fall_r <= (fall_r == 3'h5) ? 3'h1 : fall_r + 3'h1;
	end

	// Bits as seen on the wire, shifted in from the top
	always_ff @(posedge clk)
	begin
		if (sclk_r && !sclk)
			sh_r <= {sdata, sh_r[4:1]};
	end

	// Cycles since enable fell in parallel mode; saturates to stay small
	always_ff @(posedge clk)
	begin
		if (!rstn || !mode_par || ce_n)
			wait_r <= 0;
		else if (wait_r < 1000)
			wait_r <= wait_r + 1;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_PULSE_SINGLE: assert property (
		code_pulse |=> !code_pulse)
		else $error("code pulse longer than one cycle");
	AST_SER_FIFTH_FALL: assert property (
		code_pulse && !mode_par |-> fall_r == 3'h5)
		else $error("serial code applied before fifth clock fall");
	AST_SER_LSB_FIRST: assert property (
		code_pulse && !mode_par && sh_r < 5'h18 |-> applied_code == sh_r)
		else $error("applied code differs from bits on the wire");
	AST_DUAL_PAIR: assert property (
		code_pulse && !applied_code[4] |-> row_active && col_active)
		else $error("digit code did not select a tone pair");
	AST_SINGLE_ROW: assert property (
		code_pulse && applied_code[4:2] == 3'b100
		|-> row_active && !col_active)
		else $error("row single tone wrong");
	AST_SINGLE_COL: assert property (
		code_pulse && applied_code[4:2] == 3'b101
		|-> !row_active && col_active)
		else $error("column single tone wrong");
	AST_TONE_OFF: assert property (
		code_pulse && applied_code == CODE_OFF
		|-> (!row_active && !col_active) [*3])
		else $error("off code left a tone running");
	AST_PAR_DELAY: assert property (
		code_pulse && mode_par |-> wait_r >= DLY && wait_r <= DLY + 10)
		else $error("parallel start delay out of range");
	AST_PAR_CODE: assert property (
		code_pulse && mode_par |-> applied_code == {1'b0, par_code})
		else $error("parallel code not applied");
	AST_PAR_ORDER: assert property (
		$fell(ce_n) && mode_par |-> $past(mode_par) && $stable(par_code))
		else $error("enable fell before mode and code settled");
	AST_SCLK_LOW: assert property (
		$fell(sclk) |-> !sclk [*4])
		else $error("serial clock low phase too short");

	COV_PAR: cover property (code_pulse && mode_par);
	COV_SINGLE: cover property (code_pulse && !mode_par && applied_code[4]);
	COV_OFF: cover property (code_pulse && applied_code == CODE_OFF);
endmodule : dtg_link_chk
`default_nettype wire

// >>> tb/test_dual_tone_code_interface.sv
// Self-checking bench: host and receiver joined face to face
`timescale 1ns/1ps
`default_nettype none
module test_dual_tone_code_interface
	import dtg_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus, design and checker
	// ------------------------------------------------------------
	localparam int DLY = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_par = 1'b0;
	logic [4:0] cmd_code = 5'h00;
	logic cmd_ready, tone_row, tone_col, row_active, col_active, code_pulse;
	logic [4:0] applied_code;
	logic [4:0] wire_sh = 5'h00;
	int miscompares = 0;
	int tests_run = 0;

	// Short counts keep the run small; expectations use DLY
	always #2 clk = ~clk;

	dtg_if u_dtg_if ();
	dtg_host #(.HALF_CYC(4), .SETUP_CYC(2)) u_dtg_host (.clk(clk),
		.rstn(rstn), .link(u_dtg_if.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_par(cmd_par), .cmd_code(cmd_code));
	dtg_device #(.START_DLY_CYC(DLY), .OSC_DLY_CYC(0)) u_dtg_device (
		.clk(clk), .rstn(rstn), .link(u_dtg_if.dev), .tone_row(tone_row),
		.tone_col(tone_col), .row_active(row_active),
		.col_active(col_active), .applied_code(applied_code),
		.code_pulse(code_pulse));
	dtg_link_chk #(.DLY(DLY)) u_dtg_link_chk (.clk(clk), .rstn(rstn),
		.mode_par(u_dtg_if.mode_par), .ce_n(u_dtg_if.ce_n),
		.sclk(u_dtg_if.sclk), .sdata(u_dtg_if.sdata),
		.par_code(u_dtg_if.par_code), .row_active(row_active),
		.col_active(col_active), .applied_code(applied_code),
		.code_pulse(code_pulse));

	// Own view of the wire: bits collected on each serial clock fall
	always @(negedge u_dtg_if.sclk)
		if (!u_dtg_if.mode_par)
			wire_sh = {u_dtg_if.sdata, wire_sh[4:1]};

	// ------------------------------------------------------------
	// Compare and command tasks
	// ------------------------------------------------------------
	task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: code %h expected %h", $time, got, exp);
		end
	endtask : chk5

	task automatic chk1(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk1

	// One command, then look at the cycle of the code pulse
	task automatic run(input logic par, input logic [4:0] code,
		input logic [4:0] exp, input logic er, input logic ec);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_par = par;
		cmd_code = code;
		@(negedge clk);
		cmd_valid = 1'b0;
		chk1(cmd_ready, 1'b0);
		n = 0;
		while (code_pulse !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		chk1(code_pulse, 1'b1);
		chk5(applied_code, exp);
		chk1(row_active, er);
		chk1(col_active, ec);
		if (par)
			chk1(n >= DLY && n <= DLY + 12, 1'b1);
		else
			chk5(wire_sh, code);
		@(negedge clk);
		// A silenced group must leave its wave low once disabled
		if (!er)
			chk1(tone_row, 1'b0);
		if (!ec)
			chk1(tone_col, 1'b0);
	endtask : run

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Test sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		// Digits, then row and column single tones over the serial link
		for (int c = 0; c < 24; c++)
			run(1'b0, 5'(c), 5'(c), c < 20, c < 16 || c > 19);
		run(1'b0, 5'h1f, 5'h1f, 1'b0, 1'b0);
		// Every parallel code; the top bit is never sent in this mode
		for (int c = 0; c < 16; c++)
			run(1'b1, 5'(c), 5'(c), 1'b1, 1'b1);
		// Back to serial after parallel operation
		run(1'b0, 5'h12, 5'h12, 1'b1, 1'b0);
		run(1'b0, 5'h1f, 5'h1f, 1'b0, 1'b0);
		report_and_stop();
	end

	// About 1640 cycles expected; six times that is a hang
	initial
	begin
		#40000;
		miscompares++;
		$display("mismatch at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule : test_dual_tone_code_interface
`default_nettype wire
